// ### src/arct_params.svh
`ifndef ARCT_PARAMS_SVH
`define ARCT_PARAMS_SVH

// register addresses on the plain register port
`define ARCT_ADDR_CTRL     8'h91
`define ARCT_ADDR_RLD_LO   8'h92
`define ARCT_ADDR_RLD_HI   8'h93
`define ARCT_ADDR_CNT_LO   8'h94
`define ARCT_ADDR_CNT_HI   8'h95
`define ARCT_ADDR_MODE     8'h96

// control register field positions
`define ARCT_CTRL_HFLAG    7
`define ARCT_CTRL_LFLAG    6
`define ARCT_CTRL_LIEN     5
`define ARCT_CTRL_CAPEN    4
`define ARCT_CTRL_SPLIT    3
`define ARCT_CTRL_RUN      2
`define ARCT_CTRL_XSEL_HI  1
`define ARCT_CTRL_XSEL_LO  0

// mode register field positions
`define ARCT_MODE_LSYS     0
`define ARCT_MODE_HSYS     1
`define ARCT_MODE_TIE      2

// reset values
`define ARCT_CTRL_RST      8'h00
`define ARCT_MODE_RST      3'h0
`define ARCT_BYTE_RST      8'h00
`define ARCT_BYTE_MAX      8'hFF

// count clock dividers
`define ARCT_SYS_DIV       12
`define ARCT_EXT_DIV       8

`endif

// ### src/arct_pkg.sv
`default_nettype none

package arct_pkg;

	typedef enum logic [1:0] {
		ARCT_SRC_SYS,
		ARCT_SRC_DIV,
		ARCT_SRC_EXT,
		ARCT_SRC_CMP
	} arct_src_e;

	typedef logic [7:0] arct_byte_t;

endpackage

`default_nettype wire

// ### src/arct_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser followed by a rising edge detector
module arct_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output var  logic rise
);

	logic meta;
	logic stable;
	logic last;
	logic next_rise;
	logic [2:0] warm;

	// no edge is reported until the edge flop holds a real pin level, so a pin
	// that idles high does not look like a rising edge right after reset
	always_comb begin
		next_rise = stable & ~last & warm[2];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
			rise   <= 1'b0;
			warm   <= 3'h0;
		end else begin
			meta   <= async_in;
			stable <= meta;
			last   <= stable;
			rise   <= next_rise;
			warm   <= {warm[1:0], 1'b1};
		end
	end

endmodule

`default_nettype wire

// ### src/arct_timer.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "arct_params.svh"

// Summary of operation
// - count is sixteen bits held in separate low and high byte registers
// - clocks: system, system/12, oscillator/8, comparator; async ones synchronised
// - split bit clear: one sixteen-bit auto-reload timer
// - sixteen-bit wrap reloads both bytes and sets the high flag
// - timer interrupt enabled: request on every sixteen-bit overflow
// - with low interrupt enable too, also request on low byte wrap
// - split bit set: two eight-bit timers each reloading from own byte
// - split mode: run bit gates only high byte, low byte always counts
// - byte system_clock select 1 picks system clock, else external select decides
// - split mode: each byte wrap sets its own overflow flag
// - split mode interrupt on high wrap, or either wrap with low enable
// - hardware never clears the flags; software clears them
// - capture enable puts the timer in capture mode
// - capture trigger: comparator rising edge or every eighth oscillator cycle
// - capture copies count into reload pair and sets high flag
// - control register at 0x91, reset zero, documented bit layout
module arct_timer
	import arct_pkg::*;
#(
	parameter int SYS_DIV = `ARCT_SYS_DIV,
	parameter int EXT_DIV = `ARCT_EXT_DIV
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic       ext_osc,
	input  wire logic       cmp_out,
	output var  logic [7:0] rd_data,
	output var  logic       timer_irq
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (SYS_DIV < 2 || SYS_DIV > 256) begin : g_sys_div_bad
		$error("SYS_DIV must lie in 2..256");
	end
	if (EXT_DIV < 2 || EXT_DIV > 256) begin : g_ext_div_bad
		$error("EXT_DIV must lie in 2..256");
	end

	localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
	localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

	// ************************************************************
	// register state
	// ************************************************************
	arct_byte_t timer_control_reg;
	logic [2:0] mode_reg;
	arct_byte_t count_low_byte;
	arct_byte_t count_high_byte;
	arct_byte_t reload_low_byte;
	arct_byte_t reload_high_byte;

	arct_byte_t next_control;
	logic [2:0] next_mode;
	arct_byte_t next_cnt_lo;
	arct_byte_t next_cnt_hi;
	arct_byte_t next_rld_lo;
	arct_byte_t next_rld_hi;

	// ************************************************************
	// field aliases
	// ************************************************************
	logic       high_overflow_flag;
	logic       low_overflow_flag;
	logic       low_interrupt_enable;
	logic       capture_enable;
	logic       split_mode_bit;
	logic       run_control_bit;
	logic [1:0] external_clock_select;
	logic       capture_trigger_select;
	logic       low_byte_system_clock_select;
	logic       high_byte_system_clock_select;
	logic       timer_irq_enable;

	assign high_overflow_flag      = timer_control_reg[`ARCT_CTRL_HFLAG];
	assign low_overflow_flag       = timer_control_reg[`ARCT_CTRL_LFLAG];
	assign low_interrupt_enable    = timer_control_reg[`ARCT_CTRL_LIEN];
	assign capture_enable          = timer_control_reg[`ARCT_CTRL_CAPEN];
	assign split_mode_bit          = timer_control_reg[`ARCT_CTRL_SPLIT];
	assign run_control_bit         = timer_control_reg[`ARCT_CTRL_RUN];
	assign external_clock_select   = timer_control_reg[`ARCT_CTRL_XSEL_HI:`ARCT_CTRL_XSEL_LO];
	assign capture_trigger_select  = timer_control_reg[`ARCT_CTRL_XSEL_HI];
	assign low_byte_system_clock_select  = mode_reg[`ARCT_MODE_LSYS];
	assign high_byte_system_clock_select = mode_reg[`ARCT_MODE_HSYS];
	assign timer_irq_enable        = mode_reg[`ARCT_MODE_TIE];

	// ************************************************************
	// synchronised external sources
	// ************************************************************
	logic osc_rise;
	logic cmp_rise;

	arct_sync u_osc_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (ext_osc),
		.rise     (osc_rise)
	);

	arct_sync u_cmp_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (cmp_out),
		.rise     (cmp_rise)
	);

	// ************************************************************
	// prescalers
	// ************************************************************
	logic [7:0] sys_cnt;
	logic [7:0] ext_cnt;
	logic [7:0] next_sys_cnt;
	logic [7:0] next_ext_cnt;
	logic       div_tick;
	logic       ext_tick;
	logic       next_div_tick;
	logic       next_ext_tick;

	always_comb begin
		next_sys_cnt  = sys_cnt + 8'h01;
		next_div_tick = 1'b0;
		if (sys_cnt == SYS_LAST) begin
			next_sys_cnt  = `ARCT_BYTE_RST;
			next_div_tick = 1'b1;
		end
		next_ext_cnt  = ext_cnt;
		next_ext_tick = 1'b0;
		if (osc_rise) begin
			next_ext_cnt = ext_cnt + 8'h01;
			if (ext_cnt == EXT_LAST) begin
				next_ext_cnt  = `ARCT_BYTE_RST;
				next_ext_tick = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_cnt  <= `ARCT_BYTE_RST;
			ext_cnt  <= `ARCT_BYTE_RST;
			div_tick <= 1'b0;
			ext_tick <= 1'b0;
		end else begin
			sys_cnt  <= next_sys_cnt;
			ext_cnt  <= next_ext_cnt;
			div_tick <= next_div_tick;
			ext_tick <= next_ext_tick;
		end
	end

	// ************************************************************
	// count clock selection
	// ************************************************************
	function automatic arct_src_e pick_src(input logic sys_sel, input logic [1:0] xsel);
		arct_src_e src;
		src = ARCT_SRC_SYS;
		if (!sys_sel) begin
			case (xsel)
				2'b00:   src = ARCT_SRC_DIV;
				2'b01:   src = ARCT_SRC_EXT;
				2'b10:   src = ARCT_SRC_DIV;
				2'b11:   src = ARCT_SRC_CMP;
				default: src = ARCT_SRC_DIV;
			endcase
		end
		return src;
	endfunction

	function automatic logic src_tick(input arct_src_e src, input logic d,
		input logic e, input logic c);
		logic t;
		t = 1'b0;
		case (src)
			ARCT_SRC_SYS: t = 1'b1;
			ARCT_SRC_DIV: t = d;
			ARCT_SRC_EXT: t = e;
			ARCT_SRC_CMP: t = c;
			default:      t = 1'b0;
		endcase
		return t;
	endfunction

	arct_src_e src_lo;
	arct_src_e src_hi;
	logic      tick_lo;
	logic      tick_hi;
	logic      cap_event;

	always_comb begin
		src_lo  = pick_src(low_byte_system_clock_select, external_clock_select);
		src_hi  = pick_src(high_byte_system_clock_select, external_clock_select);
		tick_lo = src_tick(src_lo, div_tick, ext_tick, cmp_rise);
		tick_hi = src_tick(src_hi, div_tick, ext_tick, cmp_rise);
		// trigger select 0 picks the comparator edge
		cap_event = capture_enable & (capture_trigger_select ? ext_tick : cmp_rise);
	end

	// ************************************************************
	// counting, reload and capture
	// ************************************************************
	logic inc_lo;
	logic inc_hi;
	logic wrap_lo;
	logic wrap_hi;

	always_comb begin
		next_cnt_lo = count_low_byte;
		next_cnt_hi = count_high_byte;
		next_rld_lo = reload_low_byte;
		next_rld_hi = reload_high_byte;
		inc_lo      = 1'b0;
		inc_hi      = 1'b0;
		wrap_lo     = 1'b0;
		wrap_hi     = 1'b0;
		if (split_mode_bit && !capture_enable) begin
			inc_lo = tick_lo;
			inc_hi = tick_hi & run_control_bit;
			wrap_lo = inc_lo && (count_low_byte == `ARCT_BYTE_MAX);
			wrap_hi = inc_hi && (count_high_byte == `ARCT_BYTE_MAX);
			if (inc_lo) begin
				next_cnt_lo = wrap_lo ? reload_low_byte : count_low_byte + 8'h01;
			end
			if (inc_hi) begin
				next_cnt_hi = wrap_hi ? reload_high_byte : count_high_byte + 8'h01;
			end
		end else begin
			// one sixteen-bit counter on the low byte's clock; run clear freezes it
			inc_lo  = tick_lo & run_control_bit;
			wrap_lo = inc_lo && (count_low_byte == `ARCT_BYTE_MAX);
			wrap_hi = wrap_lo && (count_high_byte == `ARCT_BYTE_MAX);
			if (inc_lo) begin
				next_cnt_lo = count_low_byte + 8'h01;
				if (wrap_lo) begin
					next_cnt_hi = count_high_byte + 8'h01;
				end
				// capture mode keeps the reload pair for captured values, so no reload
				if (wrap_hi && !capture_enable) begin
					next_cnt_lo = reload_low_byte;
					next_cnt_hi = reload_high_byte;
				end
			end
			if (cap_event) begin
				next_rld_lo = count_low_byte;
				next_rld_hi = count_high_byte;
			end
		end
		if (wr_en) begin
			case (addr)
				`ARCT_ADDR_CNT_LO: next_cnt_lo = wr_data;
				`ARCT_ADDR_CNT_HI: next_cnt_hi = wr_data;
				`ARCT_ADDR_RLD_LO: next_rld_lo = wr_data;
				`ARCT_ADDR_RLD_HI: next_rld_hi = wr_data;
				default: ;
			endcase
		end
	end

	// ************************************************************
	// control, flags and mode
	// ************************************************************
	logic set_hflag;
	logic set_lflag;

	always_comb begin
		// low flag follows the low byte wrap in either mode
		set_lflag = wrap_lo;
		set_hflag = (wrap_hi && !capture_enable) || cap_event;
		next_control = timer_control_reg;
		next_mode    = mode_reg;
		if (wr_en && addr == `ARCT_ADDR_CTRL) begin
			next_control = wr_data;
		end
		if (wr_en && addr == `ARCT_ADDR_MODE) begin
			next_mode = wr_data[2:0];
		end
		// a hardware set beats a software clear in the same cycle
		if (set_hflag) begin
			next_control[`ARCT_CTRL_HFLAG] = 1'b1;
		end
		if (set_lflag) begin
			next_control[`ARCT_CTRL_LFLAG] = 1'b1;
		end
	end

	// ************************************************************
	// interrupt request and read port
	// ************************************************************
	logic       next_irq;
	arct_byte_t next_rd;

	always_comb begin
		// level request while an enabled flag stands; both flags share it
		next_irq = timer_irq_enable &
			(next_control[`ARCT_CTRL_HFLAG] |
			(next_control[`ARCT_CTRL_LIEN] & next_control[`ARCT_CTRL_LFLAG]));
		next_rd = `ARCT_BYTE_RST;
		if (rd_en) begin
			case (addr)
				`ARCT_ADDR_CTRL:   next_rd = timer_control_reg;
				`ARCT_ADDR_MODE:   next_rd = {5'h00, mode_reg};
				`ARCT_ADDR_CNT_LO: next_rd = count_low_byte;
				`ARCT_ADDR_CNT_HI: next_rd = count_high_byte;
				`ARCT_ADDR_RLD_LO: next_rd = reload_low_byte;
				`ARCT_ADDR_RLD_HI: next_rd = reload_high_byte;
				default:           next_rd = `ARCT_BYTE_RST;
			endcase
		end
	end

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_control_reg <= `ARCT_CTRL_RST;
			mode_reg          <= `ARCT_MODE_RST;
			count_low_byte    <= `ARCT_BYTE_RST;
			count_high_byte   <= `ARCT_BYTE_RST;
			reload_low_byte   <= `ARCT_BYTE_RST;
			reload_high_byte  <= `ARCT_BYTE_RST;
			timer_irq         <= 1'b0;
			rd_data           <= `ARCT_BYTE_RST;
		end else begin
			timer_control_reg <= next_control;
			mode_reg          <= next_mode;
			count_low_byte    <= next_cnt_lo;
			count_high_byte   <= next_cnt_hi;
			reload_low_byte   <= next_rld_lo;
			reload_high_byte  <= next_rld_hi;
			timer_irq         <= next_irq;
			rd_data           <= next_rd;
		end
	end

endmodule

`default_nettype wire

// ### testbench/arct_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "arct_params.svh"
// ********
// port checker
// ********
module arct_timer_chk (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic       ext_osc,
	input wire logic       cmp_out,
	input wire logic [7:0] rd_data,
	input wire logic       timer_irq
);
	logic       rd_q;
	logic       hseen;
	logic       rlo_ok;
	logic [5:0] cfg;
	logic [2:0] mode;
	logic [7:0] rlo;
	logic       ctl_wr;
	assign ctl_wr = wr_en && addr == `ARCT_ADDR_CTRL;
	// shadows hold only what software alone can change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 1'b0;
			hseen <= 1'b0;
			rlo_ok <= 1'b0;
			cfg <= 6'h00;
			mode <= 3'h0;
			rlo <= 8'h00;
		end else begin
			rd_q <= rd_en && addr == `ARCT_ADDR_CTRL;
			hseen <= ctl_wr ? 1'b0 : (hseen || (rd_q && rd_data[7]));
			if (ctl_wr)
				cfg <= wr_data[5:0];
			if (wr_en && addr == `ARCT_ADDR_MODE)
				mode <= wr_data[2:0];
			if (wr_en && addr == `ARCT_ADDR_RLD_LO)
				rlo <= wr_data;
			// a capture may overwrite the reload byte at any time
			if (cfg[4])
				rlo_ok <= 1'b0;
			else if (wr_en && addr == `ARCT_ADDR_RLD_LO)
				rlo_ok <= 1'b1;
		end
	end
	property p_rd_idle;
		@(posedge clk) disable iff (!rst_n) !rd_en |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		rd_en && (addr < `ARCT_ADDR_CTRL || addr > `ARCT_ADDR_MODE) |=> rd_data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_cfg;
		@(posedge clk) disable iff (!rst_n)
		rd_en && addr == `ARCT_ADDR_CTRL |=> rd_data[5:0] == cfg;
	endproperty
	a_cfg: assert property (p_cfg) else $error("control bits wrong");
	property p_mode;
		@(posedge clk) disable iff (!rst_n)
		rd_en && addr == `ARCT_ADDR_MODE |=> rd_data == {5'h00, mode};
	endproperty
	a_mode: assert property (p_mode) else $error("mode bits wrong");
	property p_rlo;
		@(posedge clk) disable iff (!rst_n)
		rd_en && addr == `ARCT_ADDR_RLD_LO && rlo_ok |=> rd_data == rlo;
	endproperty
	a_rlo: assert property (p_rlo) else $error("reload byte changed");
	property p_irq_gate;
		@(posedge clk) disable iff (!rst_n) !mode[2] ##1 !mode[2] |-> !timer_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
	property p_irq_flag;
		@(posedge clk) disable iff (!rst_n)
		rd_q && mode[2] && (rd_data[7] || (rd_data[6] && cfg[5])) |-> timer_irq;
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("irq missing");
	property p_hold;
		@(posedge clk) disable iff (!rst_n) rd_q && hseen |-> rd_data[7];
	endproperty
	a_hold: assert property (p_hold) else $error("high flag cleared");
endmodule
bind arct_timer arct_timer_chk chk_u (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .ext_osc(ext_osc),
	.cmp_out(cmp_out), .rd_data(rd_data), .timer_irq(timer_irq));
`default_nettype wire

// ### testbench/arct_far.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// oscillator and comparator
// ********
module arct_far (
	input  wire logic osc_en,
	input  wire logic cmp_lvl,
	output var  logic ext_osc,
	output var  logic cmp_out
);
	initial ext_osc = 1'b0;
	initial cmp_out = 1'b0;
	// stands still while disabled; period unrelated to the system clock
	always #31 if (osc_en) ext_osc = !ext_osc;
	// analogue delay so edges never line up with the clock
	always @(cmp_lvl) cmp_out <= #7 cmp_lvl;
endmodule
`default_nettype wire

// ### testbench/auto_reload_capture_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "arct_params.svh"
module auto_reload_capture_timer_tb_top;
	import arct_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} arct_row_s;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       osc_en = 1'b0;
	logic       cmp_lvl = 1'b0;
	logic       ext_osc;
	logic       cmp_out;
	logic [7:0] rd_data;
	logic       timer_irq;
	logic [7:0] held;
	int         failures = 0;
	int         samples_checked = 0;
	arct_row_s  rows [9] = '{'{8'h92, 8'hA5, 8'hA5}, '{8'h93, 8'h5A, 8'h5A},
		'{8'h96, 8'hFF, 8'h07}, '{8'h96, 8'h00, 8'h00}, '{8'h94, 8'hC3, 8'hC3},
		'{8'h95, 8'h3C, 8'h3C}, '{8'h91, 8'h23, 8'h23}, '{8'h97, 8'hFF, 8'h00},
		'{8'h90, 8'hFF, 8'h00}};
	always #10 clk = !clk;
	arct_timer #(.SYS_DIV(12), .EXT_DIV(8)) dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .ext_osc(ext_osc),
		.cmp_out(cmp_out), .rd_data(rd_data), .timer_irq(timer_irq));
	arct_far far_u (.osc_en(osc_en), .cmp_lvl(cmp_lvl), .ext_osc(ext_osc), .cmp_out(cmp_out));
	// ********
	// bus tasks and checks
	// ********
	task automatic chk(input logic [7:0] v, input logic [7:0] e, input logic [7:0] m);
		samples_checked++;
		if ((v & m) !== (e & m)) begin
			failures++;
			$display("[ERR] %0t: got %h want %h", $time, v, e);
		end
	endtask
	// each transfer leaves an idle cycle so no strobe is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] v;
		rd(a, v);
		chk(v, e, m);
	endtask
	task automatic irq(input logic e);
		chk({7'h00, timer_irq}, {7'h00, e}, 8'hFF);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic reset;
		rst_n <= 1'b0;
		idle(8);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(20 * 4000);
		failures++;
		$display("[ERR] %0t: watchdog ran out", $time);
		close_out();
	end
	// ********
	// main sequence
	// ********
	initial begin
		@(posedge clk);
		reset();
		for (int a = 8'h91; a <= 8'h96; a++)
			rc(a[7:0], 8'h00, 8'hFF);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e, 8'hFF);
		end
		// sixteen-bit wrap, reload and stop
		wr(8'h96, 8'h07);
		wr(8'h92, 8'h34);
		wr(8'h93, 8'h12);
		wr(8'h94, 8'hFE);
		wr(8'h95, 8'hFF);
		wr(8'h91, 8'h04);
		idle(4);
		rc(8'h91, 8'h84, 8'hBF);
		rc(8'h91, 8'h84, 8'hBF);
		irq(1'b1);
		wr(8'h91, 8'h00);
		irq(1'b0);
		rd(8'h94, held);
		idle(3);
		rc(8'h94, held, 8'hFF);
		rc(8'h95, 8'h12, 8'hFF);
		// split mode: low byte free, high byte gated
		wr(8'h92, 8'hF0);
		wr(8'h93, 8'h77);
		wr(8'h94, 8'hFF);
		wr(8'h95, 8'hFF);
		wr(8'h91, 8'h08);
		idle(2);
		rc(8'h91, 8'h48, 8'hFF);
		rc(8'h95, 8'hFF, 8'hFF);
		rc(8'h94, 8'hF0, 8'hF0);
		wr(8'h94, 8'hF0);
		rc(8'h94, 8'hF1, 8'hFF);
		irq(1'b0);
		wr(8'h91, 8'h28);
		idle(18);
		irq(1'b1);
		rc(8'h91, 8'h68, 8'hFF);
		wr(8'h91, 8'h0C);
		idle(3);
		rc(8'h91, 8'h80, 8'h80);
		// capture on comparator edge, then every eighth oscillator cycle
		wr(8'h91, 8'h00);
		wr(8'h96, 8'h01);
		wr(8'h94, 8'h00);
		wr(8'h95, 8'h00);
		wr(8'h91, 8'h14);
		idle(5);
		rc(8'h91, 8'h00, 8'h80);
		cmp_lvl <= 1'b1;
		idle(8);
		rc(8'h91, 8'h80, 8'h80);
		rc(8'h93, 8'h00, 8'hFF);
		rc(8'h92, 8'h00, 8'hF0);
		cmp_lvl <= 1'b0;
		wr(8'h91, 8'h16);
		osc_en <= 1'b1;
		idle(12);
		rc(8'h91, 8'h00, 8'h80);
		idle(20);
		rc(8'h91, 8'h80, 8'h80);
		// system clock over twelve: 49 edges give four or five counts
		wr(8'h91, 8'h00);
		wr(8'h96, 8'h00);
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h04);
		idle(48);
		rc(8'h94, 8'h04, 8'hFE);
		// reset in mid-run
		reset();
		rc(8'h91, 8'h00, 8'hFF);
		rc(8'h96, 8'h00, 8'hFF);
		irq(1'b0);
		close_out();
	end
endmodule
`default_nettype wire
